// ==== core/cpu_register_file_status.sv ====
// working register file, pointers, data space mapping and status flags of the cpu core
// Summary of operation
// - 32 byte registers, single cycle access
// - two operands out, result back, one cycle
// - byte/byte, two byte, byte-to-word, word-to-word ports
// - registers 26..31 form three 16-bit pointers
// - third pointer addresses program flash lookups
// - pointer displacement, post-increment, pre-decrement
// - data addresses 0..31 reach the registers
// - io space seen at data 0x20..0x5f
// - extended io only via load/store families
// - register and immediate arithmetic in one cycle
// - next instruction fetched while one executes
// - instructions are one or two words
// - return address pushed to stack on call/interrupt
// - flags updated after add, sub, logic and word immediate operations
// - flags never saved or restored by hardware
// - global enable clear blocks every interrupt
// - enable cleared on interrupt, set on return
// - bool holder copies register bits both ways
// - nibble carry from low nibble on add/sub
// - polarity flag equals negative xor overflow
// - overflow flag marks signed wrap
// - negative, zero and carry flags
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module cpu_register_file_status
  import cpu_core_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  // classic wishbone slave
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic wb_ack_o,
  // decoder request and alu facing operands
  input wire exec_req_type exec_req,
  output logic busy,
  output logic [7:0] operand_a,
  output logic [7:0] operand_b,
  output logic [15:0] operand_word,
  // interrupt gating
  input wire logic irq_request,
  output logic irq_allowed,
  output logic [7:0] status_flags_reg,
  // data memory bus, combinational read
  output dmem_req_type dmem,
  input wire logic [7:0] dmem_rdata,
  input wire logic [15:0] stack_top_pointer,
  // program memory
  output logic [15:0] program_counter,
  input wire logic [15:0] pm_rdata,
  output logic [15:0] fetched_word,
  output logic [15:0] flash_addr
);
  logic [7:0] regs [REG_COUNT]; // working registers
  logic [7:0] next_regs [REG_COUNT];
  logic [7:0] flags; // stored flags, bit 4 derived on read
  logic [7:0] next_flags;
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic [15:0] fetch_q; // prefetched instruction word
  logic [15:0] next_fetch_q;
  logic [15:0] ret_addr; // return address awaiting its high byte push
  logic [15:0] next_ret_addr;
  core_state_type state;
  core_state_type next_state;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  // write ports: two byte ports, one pointer update port, one bus port
  logic w0_en, w1_en, pw_en;
  logic [4:0] w0_idx, w1_idx, pw_idx;
  logic [7:0] w0_dat, w1_dat;
  logic [15:0] pw_val;
  logic bus_access, bus_reg_we;
  logic go; // request accepted this cycle
  logic [15:0] ptr_x, ptr_y, ptr_z;

  // pointer pairs, even register low byte
  assign ptr_x = {regs[PTR_A_LO + 5'd1], regs[PTR_A_LO]};
  assign ptr_y = {regs[PTR_B_LO + 5'd1], regs[PTR_B_LO]};
  assign ptr_z = {regs[PTR_C_LO + 5'd1], regs[PTR_C_LO]};
  assign flash_addr = ptr_z;
  // polarity flag never stored, so it cannot drift from its sources
  assign status_flags_reg = {flags[7:5], flags[FLAG_NEG] ^ flags[FLAG_OVF], flags[3:0]};
  assign irq_allowed = irq_request & flags[FLAG_GIE];
  assign busy = (state != ST_RUN);
  assign go = exec_req.valid & (state == ST_RUN);
  assign program_counter = pc;
  assign fetched_word = fetch_q;
  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  // operand read ports, pure muxes of flops
  assign operand_a = regs[exec_req.rd];
  assign operand_b = exec_req.use_imm ? exec_req.imm : regs[exec_req.rr];
  assign operand_word = {regs[{exec_req.rd[4:1], 1'b1}], regs[{exec_req.rd[4:1], 1'b0}]};
  assign bus_access = wb_cyc_i & wb_stb_i & ~ack;
  assign bus_reg_we = bus_access & wb_we_i & wb_sel_i[0] & wb_adr_i[WB_REGS_BIT];

  // execute: alu, flags, pointers, data space and program counter
  always_comb begin
    logic [8:0] r9;
    logic [16:0] r17;
    logic [7:0] a, b, r;
    logic [15:0] pv, addr;
    logic cin;
    r9 = 9'h000;
    r17 = 17'h00000;
    a = operand_a;
    b = operand_b;
    r = 8'h00;
    pv = 16'h0000;
    addr = 16'h0000;
    cin = flags[FLAG_CARRY];
    w0_en = 1'b0;
    w0_idx = exec_req.rd;
    w0_dat = 8'h00;
    w1_en = 1'b0;
    w1_idx = {exec_req.rd[4:1], 1'b1};
    w1_dat = 8'h00;
    pw_en = 1'b0;
    pw_idx = PTR_A_LO;
    pw_val = 16'h0000;
    dmem = '0;
    next_state = state;
    next_ret_addr = ret_addr;
    next_pc = pc;
    next_fetch_q = fetch_q;
    // software write to the flags register, any core update below wins
    next_flags = flags;
    if (bus_access && wb_we_i && wb_sel_i[0] && wb_adr_i == WB_STATUS) begin
      next_flags = wb_dat_i[7:0];
    end
    // pointer selection and effective address
    case (exec_req.ptr_sel)
      PTR_B: begin
        pv = ptr_y;
        pw_idx = PTR_B_LO;
      end
      PTR_C: begin
        pv = ptr_z;
        pw_idx = PTR_C_LO;
      end
      default: begin
        pv = ptr_x;
        pw_idx = PTR_A_LO;
      end
    endcase
    if (state == ST_PUSH_HI) begin
      // second stack byte, decoder is held off meanwhile
      dmem = '{req: 1'b1, we: 1'b1, addr: stack_top_pointer - 16'd1, wdata: ret_addr[15:8]};
      next_state = ST_RUN;
    end else if (go) begin
      // fetch of the next word overlaps this execution
      next_fetch_q = pm_rdata;
      next_pc = pc + (exec_req.long_word ? 16'd2 : 16'd1);
      case (exec_req.op)
        OP_ADD, OP_ADC: begin
          r9 = {1'b0, a} + {1'b0, b} + {8'h00, (exec_req.op == OP_ADC) & cin};
          r = r9[7:0];
          w0_en = 1'b1;
          w0_dat = r;
          next_flags[FLAG_HALF] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
          next_flags[FLAG_OVF] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
          next_flags[FLAG_CARRY] = r9[8];
          next_flags[FLAG_NEG] = r[7];
          next_flags[FLAG_ZERO] = (r == 8'h00);
        end
        OP_SUB, OP_SBC: begin
          r9 = {1'b0, a} - {1'b0, b} - {8'h00, (exec_req.op == OP_SBC) & cin};
          r = r9[7:0];
          w0_en = 1'b1;
          w0_dat = r;
          next_flags[FLAG_HALF] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
          next_flags[FLAG_OVF] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
          next_flags[FLAG_CARRY] = r9[8];
          next_flags[FLAG_NEG] = r[7];
          // with borrow the zero flag chains across bytes
          next_flags[FLAG_ZERO] = (r == 8'h00) & ((exec_req.op == OP_SUB) | flags[FLAG_ZERO]);
        end
        OP_AND, OP_OR, OP_EOR: begin
          r = (exec_req.op == OP_AND) ? (a & b) : (exec_req.op == OP_OR) ? (a | b) : (a ^ b);
          w0_en = 1'b1;
          w0_dat = r;
          next_flags[FLAG_OVF] = 1'b0;
          next_flags[FLAG_NEG] = r[7];
          next_flags[FLAG_ZERO] = (r == 8'h00);
        end
        OP_MOV: begin
          w0_en = 1'b1;
          w0_dat = b;
        end
        OP_ADDW, OP_SUBW: begin
          // word immediate on a register pair, one cycle
          if (exec_req.op == OP_ADDW) begin
            r17 = {1'b0, operand_word} + {11'h000, exec_req.imm[5:0]};
            next_flags[FLAG_OVF] = ~operand_word[15] & r17[15];
          end else begin
            r17 = {1'b0, operand_word} - {11'h000, exec_req.imm[5:0]};
            next_flags[FLAG_OVF] = operand_word[15] & ~r17[15];
          end
          w0_en = 1'b1;
          w0_idx = {exec_req.rd[4:1], 1'b0};
          w0_dat = r17[7:0];
          w1_en = 1'b1;
          w1_dat = r17[15:8];
          next_flags[FLAG_CARRY] = r17[16];
          next_flags[FLAG_NEG] = r17[15];
          next_flags[FLAG_ZERO] = (r17[15:0] == 16'h0000);
        end
        OP_MOVW: begin
          w0_en = 1'b1;
          w0_idx = {exec_req.rd[4:1], 1'b0};
          w0_dat = regs[{exec_req.rr[4:1], 1'b0}];
          w1_en = 1'b1;
          w1_dat = regs[{exec_req.rr[4:1], 1'b1}];
        end
        OP_WIDE: begin
          // two byte operands went out, a word result comes back
          w0_en = 1'b1;
          w0_idx = {exec_req.rd[4:1], 1'b0};
          w0_dat = exec_req.wide_data[7:0];
          w1_en = 1'b1;
          w1_dat = exec_req.wide_data[15:8];
        end
        OP_TO_FLAG: next_flags[FLAG_BOOL] = a[exec_req.bit_sel];
        OP_TO_REG: begin
          w0_en = 1'b1;
          w0_dat = a;
          w0_dat[exec_req.bit_sel] = flags[FLAG_BOOL];
        end
        OP_SEI: next_flags[FLAG_GIE] = 1'b1;
        OP_CLI: next_flags[FLAG_GIE] = 1'b0;
        OP_IRQ, OP_CALL: begin
          // interrupt returns to this instruction, a call to the next one
          next_ret_addr = (exec_req.op == OP_IRQ) ? pc : next_pc;
          dmem = '{req: 1'b1, we: 1'b1, addr: stack_top_pointer, wdata: next_ret_addr[7:0]};
          next_state = ST_PUSH_HI;
          next_pc = exec_req.target;
          // flags other than the enable are left as they are, software saves them itself
          if (exec_req.op == OP_IRQ) begin
            next_flags[FLAG_GIE] = 1'b0;
          end
        end
        OP_IRQ_RET: begin
          next_pc = exec_req.target; // popped address given by the stack logic
          next_flags[FLAG_GIE] = 1'b1;
        end
        OP_LD, OP_ST, OP_IN, OP_OUT, OP_LDS, OP_STS: begin
          if (exec_req.op == OP_IN || exec_req.op == OP_OUT) begin
            // six bit io number can only land in 0x20..0x5f
            addr = IO_BASE + {10'h000, exec_req.io_addr};
          end else if (exec_req.op == OP_LDS || exec_req.op == OP_STS) begin
            addr = exec_req.target;
          end else begin
            case (exec_req.ptr_mode)
              PM_POSTINC: begin
                addr = pv;
                pw_en = 1'b1;
                pw_val = pv + 16'd1;
              end
              PM_PREDEC: begin
                addr = pv - 16'd1;
                pw_en = 1'b1;
                pw_val = addr;
              end
              PM_DISP: addr = pv + {10'h000, exec_req.disp};
              default: addr = pv;
            endcase
          end
          if (exec_req.op == OP_LD || exec_req.op == OP_IN || exec_req.op == OP_LDS) begin
            w0_en = 1'b1;
            if (addr <= REG_SPACE_END) begin
              w0_dat = regs[addr[4:0]];
            end else begin
              dmem = '{req: 1'b1, we: 1'b0, addr: addr, wdata: 8'h00};
              w0_dat = dmem_rdata;
            end
          end else if (addr <= REG_SPACE_END) begin
            w1_en = 1'b1;
            w1_idx = addr[4:0];
            w1_dat = a;
          end else begin
            dmem = '{req: 1'b1, we: 1'b1, addr: addr, wdata: a};
          end
        end
        default: ;
      endcase
    end
  end

  // per register next value: byte ports, then pointer update, then bus
  generate
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
      localparam logic [4:0] IDX = 5'(i); // index at port width, a genvar is not sliced
      always_comb begin
        if (w0_en && w0_idx == IDX) begin
          next_regs[i] = w0_dat;
        end else if (w1_en && w1_idx == IDX) begin
          next_regs[i] = w1_dat;
        end else if (pw_en && pw_idx == IDX) begin
          next_regs[i] = pw_val[7:0];
        end else if (pw_en && {pw_idx[4:1], 1'b1} == IDX) begin
          next_regs[i] = pw_val[15:8];
        end else if (bus_reg_we && wb_adr_i[6:2] == IDX) begin
          next_regs[i] = wb_dat_i[7:0];
        end else begin
          next_regs[i] = regs[i];
        end
      end
    end
  endgenerate

  // wishbone answer: ack one cycle after the strobe, unmapped reads give zero
  always_comb begin
    next_ack = bus_access;
    next_rdata = rdata;
    if (bus_access && !wb_we_i) begin
      if (wb_adr_i[WB_REGS_BIT]) begin
        next_rdata = {24'h000000, regs[wb_adr_i[6:2]]};
      end else begin
        case (wb_adr_i)
          WB_STATUS: next_rdata = {24'h000000, status_flags_reg};
          WB_PC: next_rdata = {16'h0000, pc};
          WB_PTR_A: next_rdata = {16'h0000, ptr_x};
          WB_PTR_B: next_rdata = {16'h0000, ptr_y};
          WB_PTR_C: next_rdata = {16'h0000, ptr_z};
          default: next_rdata = 32'h00000000;
        endcase
      end
    end
  end

  // state registers only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= 8'h00;
      end
      flags <= STATUS_RESET;
      pc <= PC_RESET;
      fetch_q <= 16'h0000;
      ret_addr <= 16'h0000;
      state <= ST_RUN;
      ack <= 1'b0;
      rdata <= 32'h00000000;
    end else begin
      regs <= next_regs;
      flags <= next_flags;
      pc <= next_pc;
      fetch_q <= next_fetch_q;
      ret_addr <= next_ret_addr;
      state <= next_state;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // checks beside the logic
  a_gie_blocks_irq: assert property (@(posedge ref_clk) disable iff (rst)
    !status_flags_reg[FLAG_GIE] |-> !irq_allowed) else $error("irq allowed while disabled");
  a_irq_clears_gie: assert property (@(posedge ref_clk) disable iff (rst)
    go && exec_req.op == OP_IRQ |=> !status_flags_reg[FLAG_GIE] && busy)
    else $error("interrupt entry left enable set");
  a_return_sets_gie: assert property (@(posedge ref_clk) disable iff (rst)
    go && exec_req.op == OP_IRQ_RET |=> status_flags_reg[FLAG_GIE])
    else $error("return did not set enable");
  a_add_result: assert property (@(posedge ref_clk) disable iff (rst)
    go && exec_req.op == OP_ADD && !bus_access |=>
    regs[$past(exec_req.rd)] == 8'($past(operand_a) + $past(operand_b))
    && status_flags_reg[FLAG_ZERO] == (regs[$past(exec_req.rd)] == 8'h00))
    else $error("add result or zero flag wrong");
  a_sign_flag: assert property (@(posedge ref_clk) disable iff (rst)
    status_flags_reg[FLAG_SIGN] == (status_flags_reg[FLAG_NEG] ^ status_flags_reg[FLAG_OVF]))
    else $error("polarity flag mismatch");
  a_postinc_ptr: assert property (@(posedge ref_clk) disable iff (rst)
    go && exec_req.op == OP_LD && exec_req.ptr_mode == PM_POSTINC && exec_req.ptr_sel == PTR_A
    && exec_req.rd < PTR_A_LO && !bus_access |=> ptr_x == $past(ptr_x) + 16'd1)
    else $error("post increment wrong");
  a_push_two: assert property (@(posedge ref_clk) disable iff (rst)
    go && exec_req.op == OP_CALL |-> dmem.we && dmem.addr == stack_top_pointer
    ##1 dmem.we && dmem.wdata == ret_addr[15:8] ##1 !busy)
    else $error("return address push wrong");
  a_bool_store: assert property (@(posedge ref_clk) disable iff (rst)
    go && exec_req.op == OP_TO_FLAG |=>
    status_flags_reg[FLAG_BOOL] == $past(operand_a[exec_req.bit_sel]))
    else $error("bool holder not loaded");
  a_reg_window: assert property (@(posedge ref_clk) disable iff (rst)
    go && exec_req.op == OP_LDS && exec_req.target <= REG_SPACE_END && !bus_access
    |-> !dmem.req) else $error("register address went to memory");
endmodule

// ==== shared/cpu_core_pkg.sv ====
// constants, operation codes and carrier types of the cpu register file and status flags
package cpu_core_pkg;
  localparam int REG_COUNT = 32;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  // pointer pairs, even register holds the low byte
  localparam logic [4:0] PTR_A_LO = 5'h1a;
  localparam logic [4:0] PTR_B_LO = 5'h1c;
  localparam logic [4:0] PTR_C_LO = 5'h1e;
  // data space map
  localparam logic [15:0] REG_SPACE_END = 16'h001f;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] IO_END = 16'h005f;
  localparam logic [15:0] EXT_IO_BASE = 16'h0060;
  localparam logic [15:0] EXT_IO_END = 16'h00ff;
  // status flag bit positions
  localparam int FLAG_GIE = 7;
  localparam int FLAG_BOOL = 6;
  localparam int FLAG_HALF = 5;
  localparam int FLAG_SIGN = 4;
  localparam int FLAG_OVF = 3;
  localparam int FLAG_NEG = 2;
  localparam int FLAG_ZERO = 1;
  localparam int FLAG_CARRY = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // wishbone byte offsets
  localparam logic [7:0] WB_STATUS = 8'h00;
  localparam logic [7:0] WB_PC = 8'h04;
  localparam logic [7:0] WB_PTR_A = 8'h08;
  localparam logic [7:0] WB_PTR_B = 8'h0c;
  localparam logic [7:0] WB_PTR_C = 8'h10;
  localparam int WB_REGS_BIT = 7;
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03, OP_SBC = 5'h04,
    OP_AND = 5'h05, OP_OR = 5'h06, OP_EOR = 5'h07, OP_MOV = 5'h08, OP_ADDW = 5'h09,
    OP_SUBW = 5'h0a, OP_MOVW = 5'h0b, OP_WIDE = 5'h0c, OP_TO_FLAG = 5'h0d, OP_TO_REG = 5'h0e,
    OP_SEI = 5'h0f, OP_CLI = 5'h10, OP_IRQ = 5'h11, OP_IRQ_RET = 5'h12, OP_CALL = 5'h13,
    OP_LD = 5'h14, OP_ST = 5'h15, OP_IN = 5'h16, OP_OUT = 5'h17, OP_LDS = 5'h18,
    OP_STS = 5'h19
  } op_type;
  typedef enum logic [1:0] {
    PM_PLAIN = 2'h0, PM_POSTINC = 2'h1, PM_PREDEC = 2'h2, PM_DISP = 2'h3
  } ptr_mode_type;
  typedef enum logic [1:0] {PTR_A = 2'h0, PTR_B = 2'h1, PTR_C = 2'h2} ptr_sel_type;
  typedef enum logic [1:0] {ST_RUN = 2'h0, ST_PUSH_HI = 2'h1} core_state_type;
  typedef struct packed {
    logic valid;
    op_type op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic use_imm;
    logic [7:0] imm;
    ptr_sel_type ptr_sel;
    ptr_mode_type ptr_mode;
    logic [5:0] disp;
    logic [5:0] io_addr;
    logic [2:0] bit_sel;
    logic [15:0] wide_data;
    logic [15:0] target;
    logic long_word;
  } exec_req_type;
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dmem_req_type;
endpackage

// ==== tb/cpu_register_file_status_tb.sv ====
// self-checking bench for the register file, pointers and status flags
`timescale 1ns/1ps
module cpu_register_file_status_tb
  import cpu_core_pkg::*;
;
  // one alu case: operands, result and flags after it
  typedef struct packed {
    op_type op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] res;
    logic [7:0] flags;
  } row_type;
  // flags start at carry only, so carry-in, borrow-in and a kept carry all show
  localparam row_type ROWS [0:9] = '{
    '{OP_ADD, 8'h7f, 8'h01, 8'h80, 8'h2c}, '{OP_ADD, 8'hff, 8'h01, 8'h00, 8'h23},
    '{OP_SUB, 8'h00, 8'h01, 8'hff, 8'h35}, '{OP_SUB, 8'h80, 8'h01, 8'h7f, 8'h38},
    '{OP_AND, 8'hf0, 8'h0f, 8'h00, 8'h03}, '{OP_OR, 8'h0f, 8'hf0, 8'hff, 8'h15},
    '{OP_MOV, 8'h12, 8'h34, 8'h34, 8'h01}, '{OP_ADC, 8'h10, 8'h0f, 8'h20, 8'h20},
    '{OP_SBC, 8'h10, 8'h0f, 8'h00, 8'h20}, '{OP_EOR, 8'h80, 8'h01, 8'h81, 8'h15}};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_stb_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_ack_o;
  exec_req_type exec_req = '0;
  logic busy;
  logic [7:0] operand_a;
  logic [7:0] operand_b;
  logic [15:0] operand_word;
  logic irq_request = 1'b0;
  logic irq_allowed;
  logic [7:0] status_flags_reg;
  dmem_req_type dmem;
  logic [7:0] dmem_rdata;
  logic [15:0] stack_top_pointer;
  logic [15:0] program_counter;
  logic [15:0] pm_rdata;
  logic [15:0] fetched_word;
  logic [15:0] flash_addr;
  int failures = 0;
  int total_checks = 0;
  dmem_req_type snap; // data bus seen in the request cycle
  logic [15:0] pc0, pm0, opw; // pc, fetch word and word operand then
  logic [7:0] opa, opb; // byte operands then
  // 200 MHz clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  cpu_register_file_status DUT (.ref_clk(ref_clk), .rst(rst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .exec_req(exec_req),
    .busy(busy), .operand_a(operand_a), .operand_b(operand_b), .operand_word(operand_word),
    .irq_request(irq_request), .irq_allowed(irq_allowed),
    .status_flags_reg(status_flags_reg), .dmem(dmem), .dmem_rdata(dmem_rdata),
    .stack_top_pointer(stack_top_pointer), .program_counter(program_counter),
    .pm_rdata(pm_rdata), .fetched_word(fetched_word), .flash_addr(flash_addr));
  far_side_model P (.ref_clk(ref_clk), .dmem(dmem), .dmem_rdata(dmem_rdata),
    .stack_top_pointer(stack_top_pointer), .program_counter(program_counter),
    .pm_rdata(pm_rdata));
  // verdict and end of run, the only exit
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // four-state compare, reports at once
  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                    output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, wd};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    // a lost ack must not hang the run
    if (wb_ack_o !== 1'b1) begin
      failures++;
      $display("FAIL %0t no bus ack", $time);
      wrap_up();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    logic [31:0] d;
    wb(1'b1, adr, wd, d);
  endtask
  // read and compare the whole word, upper bits must read 0
  task automatic rdc(input logic [7:0] adr, input logic [15:0] exp, input string msg);
    logic [31:0] d;
    wb(1'b0, adr, 8'h00, d);
    chk(d[15:0], exp, msg);
    chk(d[31:16], 16'h0, "upper bits");
  endtask
  // one exec request, snapshots taken in its own cycle
  task automatic ex(input exec_req_type r);
    @(posedge ref_clk);
    exec_req <= r;
    #1;
    snap = dmem;
    pc0 = program_counter;
    pm0 = pm_rdata;
    opa = operand_a;
    opb = operand_b;
    opw = operand_word;
    @(posedge ref_clk);
    exec_req <= '0;
    #1;
  endtask
  function automatic exec_req_type mk(input op_type op, input logic [4:0] rd,
                                      input logic [4:0] rr);
    exec_req_type r;
    r = '0;
    r.valid = 1'b1;
    r.op = op;
    r.rd = rd;
    r.rr = rr;
    return r;
  endfunction
  // hang guard
  initial begin
    #400000;
    failures++;
    $display("FAIL %0t run too long", $time);
    wrap_up();
  end
  // main sequence
  initial begin
    exec_req_type r;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(WB_STATUS, 16'h0, "flags reset");
    irq_request <= 1'b1;
    #1;
    chk(irq_allowed, 16'h0, "gate closed");
    // every register written then read back
    for (int n = 0; n < 32; n++) wr(8'(8'h80 + 4 * n), 8'(n ^ 8'h5a));
    for (int n = 0; n < 32; n++) rdc(8'(8'h80 + 4 * n), 16'(n ^ 8'h5a), "reg");
    // alu table on r1, r2
    foreach (ROWS[i]) begin
      wr(8'h84, ROWS[i].a);
      wr(8'h88, ROWS[i].b);
      wr(WB_STATUS, 8'h01);
      ex(mk(ROWS[i].op, 5'd1, 5'd2));
      chk(opa, ROWS[i].a, "operand a");
      chk(opb, ROWS[i].b, "operand b");
      chk(fetched_word, pm0, "prefetch");
      chk(program_counter, pc0 + 16'h1, "pc step");
      chk(status_flags_reg, ROWS[i].flags, "flags");
      rdc(8'h84, ROWS[i].res, "result");
    end
    // pointer pairs, even register low
    wr(8'he8, 8'h03);
    wr(8'hec, 8'h00);
    wr(8'hf0, 8'h41);
    wr(8'hf4, 8'h00);
    wr(8'hf8, 8'hcd);
    wr(8'hfc, 8'hab);
    rdc(WB_PTR_A, 16'h0003, "ptr a");
    rdc(WB_PTR_B, 16'h0041, "ptr b");
    rdc(WB_PTR_C, 16'habcd, "ptr c");
    chk(flash_addr, 16'habcd, "flash addr");
    ex(mk(OP_NOP, 5'd30, 5'd0));
    chk(opw, 16'habcd, "word operand");
    r = mk(OP_ADDW, 5'd30, 5'd0);
    r.imm = 8'h3f;
    ex(r);
    rdc(WB_PTR_C, 16'hac0c, "word add");
    // load through a with post increment hits register 3
    r = mk(OP_LD, 5'd5, 5'd0);
    r.ptr_sel = PTR_A;
    r.ptr_mode = PM_POSTINC;
    ex(r);
    chk(snap.req, 1'b0, "ld off bus");
    rdc(8'h94, 16'h0059, "ld reg");
    rdc(WB_PTR_A, 16'h0004, "post inc");
    r = mk(OP_ST, 5'd5, 5'd5);
    r.ptr_sel = PTR_B;
    r.ptr_mode = PM_PREDEC;
    ex(r);
    chk({snap.we, snap.addr}, 17'h10040, "st addr");
    rdc(WB_PTR_B, 16'h0040, "pre dec");
    r = mk(OP_LD, 5'd6, 5'd0);
    r.ptr_sel = PTR_B;
    r.ptr_mode = PM_DISP;
    r.disp = 6'h05;
    ex(r);
    chk(snap.addr, 16'h0045, "disp addr");
    rdc(8'h98, 16'h0079, "disp data");
    rdc(WB_PTR_B, 16'h0040, "disp keeps ptr");
    // io space after the registers, extended only by long forms
    r = mk(OP_OUT, 5'd5, 5'd5);
    r.io_addr = 6'h01;
    ex(r);
    chk({snap.we, snap.addr}, 17'h10021, "out addr");
    r = mk(OP_IN, 5'd7, 5'd0);
    r.io_addr = 6'h3f;
    ex(r);
    chk({snap.we, snap.addr}, 17'h0005f, "in addr");
    r = mk(OP_LDS, 5'd7, 5'd0);
    r.target = 16'h0060;
    r.long_word = 1'b1;
    ex(r);
    chk(snap.addr, 16'h0060, "lds addr");
    chk(program_counter, pc0 + 16'h2, "two words");
    r = mk(OP_LDS, 5'd8, 5'd0);
    r.target = 16'h0003;
    ex(r);
    rdc(8'ha0, 16'h0059, "lds reg space");
    // bit copy both ways: r5 bit3 to holder, holder to r1 bit1
    r = mk(OP_TO_FLAG, 5'd5, 5'd0);
    r.bit_sel = 3'h3;
    ex(r);
    chk(status_flags_reg[6], 1'b1, "bit store");
    r = mk(OP_TO_REG, 5'd1, 5'd0);
    r.bit_sel = 3'h1;
    ex(r);
    rdc(8'h84, 16'h0083, "bit load");
    r = mk(OP_ADD, 5'd1, 5'd0);
    r.use_imm = 1'b1;
    r.imm = 8'h11;
    ex(r);
    rdc(8'h84, 16'h0094, "imm add");
    // return sets enable, interrupt clears it and pushes pc
    r = mk(OP_IRQ_RET, 5'd0, 5'd0);
    r.target = 16'h1234;
    ex(r);
    chk({status_flags_reg[7], program_counter}, 17'h11234, "return");
    chk(irq_allowed, 1'b1, "gate open");
    ex(mk(OP_IRQ, 5'd0, 5'd0));
    chk({busy, status_flags_reg[7], irq_allowed}, 3'b100, "entry");
    chk(status_flags_reg[6], 1'b1, "flags kept");
    @(posedge ref_clk);
    #1;
    chk(busy, 1'b0, "push done");
    chk({P.mem[8'hf0], P.mem[8'hef]}, 16'h3412, "pushed pc");
    ex(mk(OP_SEI, 5'd0, 5'd0));
    chk(status_flags_reg[7], 1'b1, "set enable");
    ex(mk(OP_CLI, 5'd0, 5'd0));
    chk(status_flags_reg[7], 1'b0, "clear enable");
    // a call pushes the address after its two words
    r = mk(OP_CALL, 5'd0, 5'd0);
    r.target = 16'h0200;
    r.long_word = 1'b1;
    ex(r);
    @(posedge ref_clk);
    #1;
    chk({P.mem[8'hef], P.mem[8'hf0]}, pc0 + 16'h2, "call push");
    chk(program_counter, 16'h0200, "call target");
    // reset again in mid-run, flags are not zero here
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(WB_STATUS, 16'h0, "flags reset again");
    wrap_up();
  end
endmodule

// ==== tb/far_side_model.sv ====
// data memory, stack address and program memory model facing the core
`timescale 1ns/1ps
module far_side_model
  import cpu_core_pkg::*;
#(
  parameter logic [15:0] STACK_ADDR = 16'h00f0
)
(
  input wire logic ref_clk,
  input wire dmem_req_type dmem,
  output logic [7:0] dmem_rdata,
  output logic [15:0] stack_top_pointer,
  input wire logic [15:0] program_counter,
  output logic [15:0] pm_rdata
);
  logic [7:0] mem [0:255]; // low data space only
  logic [7:0] last_rd = 8'h00; // last byte handed out
  // fixed stack top so that pushed bytes are easy to find
  assign stack_top_pointer = STACK_ADDR;
  // distinct word per address, a stale prefetch shows up
  assign pm_rdata = program_counter ^ 16'ha5c3;
  // idle read bus shows the inverse of the last byte, not a stale copy
  assign dmem_rdata = (dmem.req && !dmem.we) ? mem[dmem.addr[7:0]] : ~last_rd;
  // stores land at the edge; flags only reach memory by software stores
  always @(posedge ref_clk) begin
    if (dmem.req && dmem.we) begin
      mem[dmem.addr[7:0]] <= dmem.wdata;
    end
    if (dmem.req && !dmem.we) begin
      last_rd <= mem[dmem.addr[7:0]];
    end
  end
  // known pattern, byte i holds i xor 0x3c
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i ^ 8'h3c);
    end
  end
endmodule
